/* core/mps_pkg.sv */
// Package of constants and types for the multiphase PWM sequencer.
package mps_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int NUM_PH = 4;
  localparam int CW = 16;
  localparam int SW = 12;
  // Default switching period in clock cycles (125 MHz clock).
  localparam logic [CW-1:0] PERIOD_DEF = 16'h04E2;
  localparam logic [CW-1:0] PERIOD_MIN = 16'h000C;

  // ----------------------------------------------------------------
  // Phase-count encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_THREE = 3'h3;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  typedef enum logic [2:0] {
    MPS_IDLE = 3'b001,
    MPS_STRAP = 3'b010,
    MPS_RUN = 3'b100
  } mps_state_t;

  typedef struct packed {
    logic [NUM_PH-1:0] drive;
    logic [NUM_PH-1:0] drive_oe;
    logic [NUM_PH-1:0] sample_win;
  } mps_pins_t;

endpackage : mps_pkg

/* core/mps_phase.sv */
// One phase channel: forced off time, sample window, held sample.
`timescale 1ns/100ps
`default_nettype none
module mps_phase (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic active_i,
  input wire logic term_i,
  input wire logic cross_i,
  input wire logic [mps_pkg::CW-1:0] off_len_i,
  input wire logic [mps_pkg::CW-1:0] win_start_i,
  input wire logic [mps_pkg::SW-1:0] sense_i,
  output logic drive_o,
  output logic win_o,
  output logic [mps_pkg::SW-1:0] held_o
);
  import mps_pkg::*;

  logic [CW-1:0] off_cnt;
  logic [SW-1:0] acc;
  logic in_off;
  wire win_now = in_off && (off_cnt >= win_start_i) && !drive_o;
  wire off_done = in_off && (off_cnt == off_len_i - 16'h0001);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_o <= 1'b0;
      in_off <= 1'b0;
      off_cnt <= '0;
      win_o <= 1'b0;
      acc <= '0;
      held_o <= '0;
    end else if (!active_i) begin
      drive_o <= 1'b0;
      in_off <= 1'b0;
      win_o <= 1'b0;
    end else if (term_i) begin
      drive_o <= 1'b0;
      in_off <= 1'b1;
      off_cnt <= '0;
      win_o <= 1'b0;
      held_o <= acc;
    end else begin
      if (in_off) begin
        off_cnt <= off_cnt + 16'h0001;
      end
      if (off_done) begin
        in_off <= 1'b0;
      end
      if (!in_off && cross_i) begin
        drive_o <= 1'b1;
      end
      win_o <= win_now;
      if (win_now) begin
        acc <= sense_i;
      end
    end
  end

  AST_OFF_LOW: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) in_off |-> !drive_o)
    else $error("drive high in forced off time");
  AST_WIN_LOW: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) win_o |-> !$past(drive_o))
    else $error("window open while high");
endmodule : mps_phase
`default_nettype wire

/* core/mps_sequencer.sv */
// Top of the multiphase PWM sequencer: straps, termination clock, phases.
`timescale 1ns/100ps
`default_nettype none
module mps_sequencer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic [mps_pkg::CW-1:0] freq_set_pin_i,
  input wire logic phase3_drive_strap_i,
  input wire logic phase4_drive_strap_i,
  input wire logic [mps_pkg::NUM_PH-1:0] cross_i,
  input wire logic [mps_pkg::NUM_PH*mps_pkg::SW-1:0] current_sense_input_i,
  output mps_pkg::mps_pins_t pins_o,
  output logic [mps_pkg::NUM_PH*mps_pkg::SW-1:0] held_o,
  output logic [2:0] phase_count_o,
  output logic running_o
);
  import mps_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [NUM_PH-1:0] cross1;
  logic [NUM_PH-1:0] cross2;
  // The period word is static while switching; its two stages only keep a
  // pin that is still settling from reaching the latch in mid-change.
  logic [CW-1:0] freq1;
  logic [CW-1:0] freq2;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= '0;
      sync2 <= '0;
      cross1 <= '0;
      cross2 <= '0;
      freq1 <= PERIOD_DEF;
      freq2 <= PERIOD_DEF;
    end else begin
      sync1 <= {enable_i, phase4_drive_strap_i, phase3_drive_strap_i};
      sync2 <= sync1;
      cross1 <= cross_i;
      cross2 <= cross1;
      freq1 <= freq_set_pin_i;
      freq2 <= freq1;
    end
  end
  wire en_s = sync2[2];
  wire s3 = sync2[0];
  wire s4 = sync2[1];

  function automatic logic [2:0] strap_count(input logic p3, input logic p4);
    logic [2:0] c;
    c = CNT_FOUR;
    if (p3 && p4) c = CNT_ONE;
    else if (p3) c = CNT_TWO;
    else if (p4) c = CNT_THREE;
    return c;
  endfunction : strap_count

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  mps_state_t state;
  mps_state_t next_state;
  logic [2:0] count;
  logic [CW-1:0] period;
  logic [2:0] slot;
  logic [CW-1:0] slot_len;
  logic [CW-1:0] slot_cnt;

  // The strap pins are the phase 3/4 drives, so they are read only while
  // those drivers are disabled, before switching begins.
  always_comb begin
    next_state = state;
    case (state)
      MPS_IDLE: if (en_s) next_state = MPS_STRAP;
      MPS_STRAP: next_state = MPS_RUN;
      MPS_RUN: if (!en_s) next_state = MPS_IDLE;
      default: next_state = MPS_IDLE;
    endcase
  end

  wire [CW-1:0] div_len = (count == CNT_ONE) ? period :
                          (count == CNT_TWO) ? {1'b0, period[CW-1:1]} :
                          (count == CNT_THREE) ? period / 16'h0003 :
                          {2'b00, period[CW-1:2]};
  wire run = (state == MPS_RUN);
  wire slot_end = run && (slot_cnt == slot_len - 16'h0001);
  wire [2:0] last_slot = count - 3'h1;
  wire [CW-1:0] per_lat = (freq2 < PERIOD_MIN) ? PERIOD_MIN : freq2;
  wire [CW-1:0] third = period / 16'h0003;
  wire [CW-1:0] sixth = period / 16'h0006;
  wire start_cyc = (state == MPS_STRAP);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= MPS_IDLE;
      count <= CNT_FOUR;
      period <= PERIOD_DEF;
      slot <= '0;
      slot_cnt <= '0;
      slot_len <= PERIOD_DEF;
    end else begin
      state <= next_state;
      if (state == MPS_IDLE && en_s) begin
        count <= strap_count(s3, s4);
        period <= per_lat;
      end
      if (start_cyc) begin
        slot <= '0;
        slot_cnt <= '0;
        slot_len <= div_len;
      end else if (slot_end) begin
        slot_cnt <= '0;
        slot <= (slot == last_slot) ? 3'h0 : slot + 3'h1;
      end else if (run) begin
        slot_cnt <= slot_cnt + 16'h0001;
      end
    end
  end

  // Phase 1 terminates at cycle start, each later phase at the end of the slot before its own.
  logic [NUM_PH-1:0] term;
  logic [NUM_PH-1:0] act;
  logic [NUM_PH-1:0] drv;
  logic [NUM_PH-1:0] win;
  genvar g;
  generate
    for (g = 0; g < NUM_PH; g++) begin : g_ph
      assign act[g] = run && (3'(g) < count);
      assign term[g] = (g == 0) ?
        (start_cyc || (slot_end && slot == last_slot)) :
        (slot_end && slot == 3'(g - 1) && 3'(g) < count);
      mps_phase u_ph (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .active_i(act[g] || (start_cyc && 3'(g) < count)),
        .term_i(term[g]),
        .cross_i(cross2[g]),
        .off_len_i(third),
        .win_start_i(sixth),
        .sense_i(current_sense_input_i[g*SW +: SW]),
        .drive_o(drv[g]),
        .win_o(win[g]),
        .held_o(held_o[g*SW +: SW])
      );
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_o <= '0;
      phase_count_o <= CNT_FOUR;
      running_o <= 1'b0;
    end else begin
      pins_o.drive <= drv;
      pins_o.drive_oe <= act;
      pins_o.sample_win <= win;
      phase_count_o <= count;
      running_o <= run;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_COUNT_FROZEN: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) run && $past(run) |-> $stable(count))
    else $error("count changed");
  AST_PH1_LOW: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) term[0] && run |=> !drv[0])
    else $error("phase 1 not low");
  AST_ONE_TERM: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) $onehot0(term))
    else $error("two terminations at once");
  AST_INACTIVE: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) run && !act[3] |-> !drv[3])
    else $error("inactive phase drives");
  // The straps that set the count were sampled two edges before run rose,
  // at the edge that left the idle state.
  AST_STRAP2: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    $rose(run) && $past(s3, 2) && !$past(s4, 2) |-> count == CNT_TWO)
    else $error("two phase strap wrong");
  AST_STRAP3: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    $rose(run) && !$past(s3, 2) && $past(s4, 2) |-> count == CNT_THREE)
    else $error("three phase strap wrong");
  AST_STRAP1: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    $rose(run) && $past(s3, 2) && $past(s4, 2) |-> count == CNT_ONE)
    else $error("one phase strap wrong");
  AST_STRAP4: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    $rose(run) && !$past(s3, 2) && !$past(s4, 2) |-> count == CNT_FOUR)
    else $error("default strap wrong");
  AST_HIGH_HOLD: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) drv[1] && !term[1] && act[1] |=> drv[1])
    else $error("fell early");
  AST_SLOT_LEN: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) run |-> slot_cnt < slot_len)
    else $error("slot counter past slot length");
  AST_SLOT_WRAP: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) run |-> slot <= last_slot)
    else $error("slot index past last active phase");
  AST_OE_IDLE: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) !running_o |-> pins_o.drive_oe == 4'h0)
    else $error("drive enabled while stopped");
endmodule : mps_sequencer
`default_nettype wire

/* verification/mps_driver_model.sv */
// Behavioural driver stages and strap ties at the sequencer's phase pins.
`timescale 1ns/100ps
`default_nettype none
module mps_driver_model #(
  parameter logic [mps_pkg::SW-1:0] SENSE_BASE = 12'h5A0
) (
  input wire logic tie3_i,
  input wire logic tie4_i,
  input wire mps_pkg::mps_pins_t pins_i,
  output logic strap3_o,
  output logic strap4_o,
  output logic [mps_pkg::NUM_PH*mps_pkg::SW-1:0] sense_o
);
  import mps_pkg::*;
  wire logic [NUM_PH-1:0] pin_hi = pins_i.drive_oe & pins_i.drive;
  // A tie to the supply wins; an untied pin is high only while its driver is enabled and driving high.
  assign strap3_o = tie3_i | pin_hi[2];
  assign strap4_o = tie4_i | pin_hi[3];
  // Sense is valid only while the lower switch conducts; otherwise the
  // inverted code shows, so a sample taken at the wrong time is caught.
  for (genvar g = 0; g < NUM_PH; g++) begin : g_ph
    wire logic [SW-1:0] val = SW'(SENSE_BASE + g);
    assign sense_o[g*SW+:SW] = pins_i.drive[g] ? ~val : val;
  end
endmodule : mps_driver_model
`default_nettype wire

/* verification/mps_sequencer_bench.sv */
// Self-checking testbench for the multiphase PWM sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module mps_sequencer_bench;
  import mps_pkg::*;
  localparam int P = 48;
  localparam logic [SW-1:0] SB = 12'h5A0;
  logic clk_i = 0, rst_b_i = 0, enable_i = 0, tie3 = 0, tie4 = 0;
  logic [NUM_PH-1:0] cross_i = '1;
  wire logic s3, s4;
  wire logic [NUM_PH*SW-1:0] sense;
  mps_pins_t pins;
  logic [NUM_PH*SW-1:0] held;
  logic [2:0] cnt;
  logic run;
  logic [NUM_PH-1:0] d_q, w_q;
  int mismatches = 0, compares = 0, cyc = 0;
  int fall_t [NUM_PH], off_t [NUM_PH], win_t [NUM_PH], wend_t [NUM_PH];

  mps_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(enable_i),
    .freq_set_pin_i(16'(P)), .phase3_drive_strap_i(s3),
    .phase4_drive_strap_i(s4), .cross_i(cross_i),
    .current_sense_input_i(sense), .pins_o(pins), .held_o(held),
    .phase_count_o(cnt), .running_o(run));
  mps_driver_model #(.SENSE_BASE(SB)) drv (.tie3_i(tie3), .tie4_i(tie4),
    .pins_i(pins), .strap3_o(s3), .strap4_o(s4), .sense_o(sense));

  initial forever #4 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Edge timing monitor
  // ----------------------------------------------------------------
  // Outputs are read at the falling edge, half a cycle after they settle.
  always @(negedge clk_i) begin
    cyc++;
    for (int g = 0; g < NUM_PH; g++) begin
      if (d_q[g] && !pins.drive[g]) fall_t[g] = cyc;
      if (!d_q[g] && pins.drive[g]) off_t[g] = cyc - fall_t[g];
      if (!w_q[g] && pins.sample_win[g]) win_t[g] = cyc - fall_t[g];
      if (w_q[g] && !pins.sample_win[g]) wend_t[g] = cyc - fall_t[g];
    end
    d_q = pins.drive;
    w_q = pins.sample_win;
  end

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_fall(input int g);
    int t = fall_t[g];
    int k = 0;
    while (fall_t[g] == t && k < 2 * P) begin
      @(negedge clk_i);
      k++;
    end
    `CHK(k < 2 * P, 1'b1)
  endtask : wait_fall

  task automatic run_mode(input logic t3, input logic t4, input int n);
    int t0;
    @(negedge clk_i);
    rst_b_i = 0;
    enable_i = 0;
    tie3 = t3;
    tie4 = t4;
    repeat (10) @(negedge clk_i);
    rst_b_i = 1;
    @(negedge clk_i);
    enable_i = 1;
    repeat (4 * P) @(negedge clk_i);
    `CHK(cnt, 3'(n))
    `CHK(pins.drive_oe, 4'((1 << n) - 1))
    wait_fall(0);
    t0 = fall_t[0];
    for (int g = 1; g < n; g++) begin
      wait_fall(g);
      `CHK(fall_t[g] - fall_t[g-1], P / n)
    end
    wait_fall(0);
    `CHK(fall_t[0] - t0, P)
    for (int g = 0; g < n; g++) begin
      `CHK(off_t[g] >= P / 3, 1'b1)
      `CHK(win_t[g] inside {[P / 6:P / 6 + 1]}, 1'b1)
      `CHK(wend_t[g] inside {[P / 3:P / 3 + 1]}, 1'b1)
      `CHK(held[g*SW+:SW], SW'(SB + g))
    end
    tie3 = !t3;
    tie4 = !t4;
    repeat (8) @(negedge clk_i);
    `CHK(cnt, 3'(n))
    `CHK(run, 1'b1)
    $display("Test with %0d active phases done", n);
  endtask : run_mode

  task automatic test_four(); run_mode(0, 0, 4); endtask : test_four
  task automatic test_two(); run_mode(1, 0, 2); endtask : test_two
  task automatic test_three(); run_mode(0, 1, 3); endtask : test_three
  task automatic test_one(); run_mode(1, 1, 1); endtask : test_one

  // Holds the comparator low through a forced off time, then lets it cross.
  task automatic test_cross();
    wait_fall(0);
    cross_i = '0;
    repeat (P / 2) @(negedge clk_i);
    `CHK(pins.drive[0], 1'b0)
    cross_i = '1;
    repeat (4) @(negedge clk_i);
    `CHK(pins.drive[0], 1'b1)
    cross_i = '0;
    repeat (4) @(negedge clk_i);
    `CHK(pins.drive[0], 1'b1)
    cross_i = '1;
    $display("Test of comparator crossing done");
  endtask : test_cross

  initial begin
    test_four();
    test_two();
    test_three();
    test_one();
    test_cross();
    give_verdict();
  end

  // All tests take about 1130 cycles; the margin covers slow waits.
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule : mps_sequencer_bench
`default_nettype wire
